// file: inc/tsq_pkg.sv
// Package for the trigger sequencer input select and output decode block
//
// Behaviour
// R1: Reserved step codes and options are consumed as steps but do nothing.
// R2: Wait options 0000/0001 pick special event and master sync; 0010-0110 PWM1-5.
// R3: Wait options 0111-1001 compare 1-2, capture 1; 1010-1101 comparators; 1110 ADC; 1111 pin irq.
// R4: Interrupt step options 0000-0011 raise interrupt 0-3; others raise nothing.
// R5: Output lines 0-3 trigger or synchronise output compare units 1-4.
// R6: Output lines 4-7 clock output compare units 1-4.
// R7: Output lines 8-11 trigger or synchronise input capture units 1-4.
// R8: Output line 12 is the ADC sample trigger.
// R9: Output lines 16 and 17 synchronise PWM time bases 3 and 4.
// R10: Output lines 30 and 31 feed remappable inputs 6 and 7.
// R11: Wait-rising step stalls until the selected input rises.
// R12: Wait-falling step stalls until the selected input falls.
// R13: Interrupt step raises the one interrupt its option selects.
// R14: Trigger steps fire one line; low opcode bit extends the option to 16-31.
// R15: Each trigger and interrupt is a one-cycle pulse in the cycle after the step is accepted.
// R16: Reserved output lines stay inactive even when selected.
package tsq_pkg;

   localparam int OPC_W = 4;
   localparam int OPT_W = 4;
   localparam int NUM_SRC = 16;
   localparam int NUM_IRQ = 4;
   localparam int NUM_LINE = 32;

   localparam logic [3:0] OPC_WAIT_RISE = 4'h4;
   localparam logic [3:0] OPC_WAIT_FALL = 4'h5;
   localparam logic [3:0] OPC_IRQ = 4'h7;
   localparam logic [2:0] OPC_TRIG_HI3 = 3'h4;

   // Wait source option codes
   localparam logic [3:0] SRC_SPECIAL_EVT = 4'h0;
   localparam logic [3:0] SRC_MASTER_SYNC = 4'h1;
   localparam logic [3:0] SRC_PWM1 = 4'h2;
   localparam logic [3:0] SRC_PWM5 = 4'h6;
   localparam logic [3:0] SRC_OUTCMP1 = 4'h7;
   localparam logic [3:0] SRC_OUTCMP2 = 4'h8;
   localparam logic [3:0] SRC_INCAP1 = 4'h9;
   localparam logic [3:0] SRC_ANACMP1 = 4'hA;
   localparam logic [3:0] SRC_ANACMP4 = 4'hD;
   localparam logic [3:0] SRC_ADC_DONE = 4'hE;
   localparam logic [3:0] SRC_EXT_IRQ2 = 4'hF;

   // Implemented output lines; reserved ones are zero
   localparam logic [31:0] LINE_USED_MASK = 32'hFC03_1FFF;

   localparam logic [NUM_SRC-1:0] SRC_RESET = 16'h0000;

   typedef struct packed {
      logic [OPC_W-1:0] opcode;
      logic [OPT_W-1:0] option;
   } tsq_step_t;

   // Event sources, ordered so that bit index equals option code
   typedef struct packed {
      logic extInt2;
      logic adcDone;
      logic [3:0] cmpEvt;
      logic capEvt;
      logic [1:0] ocEvt;
      logic [4:0] pwmIrq;
      logic masterSync;
      logic specialEvt;
   } tsq_src_t;

   typedef struct packed {
      logic [1:0] pinSelIn;
      logic [3:0] logicCellIn;
      logic [1:0] pwmSync;
      logic adcSample;
      logic [3:0] icSync;
      logic [3:0] ocClk;
      logic [3:0] ocSync;
   } tsq_lines_t;

endpackage

// file: src/tsq_sync2.sv
// Two-flop synchroniser for a bus of event inputs
module tsq_sync2
   import tsq_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1_reg <= '0;
         syncOut <= '0;
      end else begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end

endmodule

// file: src/tsq_edge_detect.sv
// Rising and falling edge detect over a synchronised event bus
module tsq_edge_detect
   import tsq_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Levels and edges
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rose,
   output logic [WIDTH-1:0] fell
);

   logic [WIDTH-1:0] prev_reg;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= level;
      end
   end

   assign rose = level & ~prev_reg;
   assign fell = ~level & prev_reg;

endmodule

// file: src/tsq_io_select.sv
// Step decoder: wait-edge input select, interrupt and trigger output decode
module tsq_io_select
   import tsq_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Step command from the fetch engine
   input wire logic stepValid,
   input wire tsq_step_t step,
   output logic stepDone,
   output logic waitBusy,
   // Event sources from peripherals
   input wire tsq_src_t eventSrc,
   // Decoded outputs
   output logic [NUM_IRQ-1:0] seqIrq,
   output tsq_lines_t lineOut
);

   typedef enum logic {
      ST_IDLE,
      ST_WAIT
   } tsq_state_t;

   tsq_state_t state_reg;
   logic waitRising_reg;
   logic [OPT_W-1:0] waitSel_reg;
   logic [NUM_SRC-1:0] srcSync;
   logic [NUM_SRC-1:0] srcRose;
   logic [NUM_SRC-1:0] srcFell;
   logic isWait;
   logic isIrq;
   logic isTrig;
   logic edgeSeen;
   logic [4:0] lineSel;
   logic [NUM_LINE-1:0] lineDec;
   logic [NUM_IRQ-1:0] irqDec;

   // Peripheral events may come from other clock gating; always resync
   tsq_sync2 #(.WIDTH(NUM_SRC)) uSync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .asyncIn(eventSrc),
      .syncOut(srcSync)
   );

   tsq_edge_detect #(.WIDTH(NUM_SRC)) uEdge (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .level(srcSync),
      .rose(srcRose),
      .fell(srcFell)
   );

   // Step accepted only while no wait is pending
   assign isWait = stepValid && (state_reg == ST_IDLE)
                   && (step.opcode == OPC_WAIT_RISE || step.opcode == OPC_WAIT_FALL);
   assign isIrq = stepValid && (state_reg == ST_IDLE) && (step.opcode == OPC_IRQ);
   assign isTrig = stepValid && (state_reg == ST_IDLE)
                   && (step.opcode[3:1] == OPC_TRIG_HI3); // R14
   assign lineSel = {step.opcode[0], step.option}; // R14

   // Option code indexes the source bus directly
   assign edgeSeen = waitRising_reg ? srcRose[waitSel_reg] // R11 R2 R3
                                    : srcFell[waitSel_reg]; // R12

   always_comb begin
      irqDec = '0;
      if (isIrq && step.option < 4'(NUM_IRQ)) begin // R4
         irqDec[step.option[1:0]] = 1'b1; // R13
      end
   end

   always_comb begin
      lineDec = '0;
      if (isTrig) begin
         lineDec[lineSel] = 1'b1;
      end
      lineDec = lineDec & LINE_USED_MASK; // R16
   end

   // Wait state machine
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         waitRising_reg <= 1'b0;
         waitSel_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (isWait) begin
                  state_reg <= ST_WAIT;
                  waitRising_reg <= (step.opcode == OPC_WAIT_RISE);
                  waitSel_reg <= step.option;
               end
            end
            ST_WAIT: begin
               if (edgeSeen) begin
                  state_reg <= ST_IDLE; // R11 R12
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         waitBusy <= 1'b0;
      end else begin
         waitBusy <= (state_reg == ST_IDLE) ? isWait : !edgeSeen;
      end
   end

   // Every non-wait step, reserved ones included, completes at once
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stepDone <= 1'b0;
      end else if (state_reg == ST_WAIT) begin
         stepDone <= edgeSeen;
      end else begin
         stepDone <= stepValid && !isWait; // R1
      end
   end

   // One-cycle pulses
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         seqIrq <= '0;
      end else begin
         seqIrq <= irqDec; // R15
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lineOut <= '0;
      end else begin
         lineOut.ocSync <= lineDec[3:0]; // R5
         lineOut.ocClk <= lineDec[7:4]; // R6
         lineOut.icSync <= lineDec[11:8]; // R7
         lineOut.adcSample <= lineDec[12]; // R8
         lineOut.pwmSync <= lineDec[17:16]; // R9
         lineOut.logicCellIn <= lineDec[29:26];
         lineOut.pinSelIn <= lineDec[31:30]; // R10
      end
   end

endmodule

// file: dv/tsq_peer_model.sv
// Behavioural event sources feeding the step decoder
module tsq_peer_model
   import tsq_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Requested levels
   input wire logic [NUM_SRC-1:0] level,
   // Event levels
   output tsq_src_t eventSrc
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NUM_SRC-1:0] levelQ = '0;
   initial eventSrc = SRC_RESET;
   // Bench moves levels at the falling edge; take them where settled to avoid a race
   always @(posedge core_clk) levelQ <= level;
   // Peripherals move off the sampling edge
   always @(negedge core_clk) eventSrc <= levelQ;
endmodule

// file: dv/tsq_io_select_sva.sv
// Port checker for the step decoder
module tsq_io_select_sva
   import tsq_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Step
   input wire logic stepValid,
   input wire tsq_step_t step,
   input wire logic stepDone,
   input wire logic waitBusy,
   // Events and outputs
   input wire tsq_src_t eventSrc,
   input wire logic [NUM_IRQ-1:0] seqIrq,
   input wire tsq_lines_t lineOut
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic take;
   logic isWait;
   logic [31:0] wide;
   tsq_step_t stepQ;
   logic [3:0] wOpt;
   logic wRise;
   logic evQ;
   logic [5:0] hist;
   assign take = stepValid && !waitBusy;
   assign isWait = step.opcode[3:1] == 3'h2;
   assign wide = {lineOut.pinSelIn, lineOut.logicCellIn, 8'h00, lineOut.pwmSync, 3'h0,
      lineOut.adcSample, lineOut.icSync, lineOut.ocClk, lineOut.ocSync};
   always_ff @(posedge core_clk) stepQ <= step;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wOpt <= 4'h0;
         wRise <= 1'b0;
      end else if (take && isWait) begin
         wOpt <= step.option;
         wRise <= step.opcode == OPC_WAIT_RISE;
      end
   end
   // Recent edges of the watched source, in the awaited direction
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         evQ <= 1'b0;
         hist <= 6'h00;
      end else begin
         evQ <= eventSrc[wOpt];
         hist <= {hist[4:0], (eventSrc[wOpt] ^ evQ) && (eventSrc[wOpt] == wRise)};
      end
   end
   chk_irq_raise:
   assert property (take && step.opcode == OPC_IRQ && step.option < 4'h4
      |=> seqIrq == 4'h1 << stepQ.option[1:0]) else $error("irq pulse wrong");
   chk_irq_quiet:
   assert property (take && !(step.opcode == OPC_IRQ && step.option < 4'h4)
      |=> seqIrq == 4'h0) else $error("unexpected irq");
   chk_trig_line:
   assert property (take && step.opcode[3:1] == OPC_TRIG_HI3
      |=> wide == ((32'h1 << {stepQ.opcode[0], stepQ.option}) & 32'hFC03_1FFF))
      else $error("trigger line wrong");
   chk_trig_quiet:
   assert property (take && step.opcode[3:1] != OPC_TRIG_HI3 |=> lineOut == '0)
      else $error("unexpected trigger");
   chk_done_next:
   assert property (take && !isWait |=> stepDone && !waitBusy) else $error("no done");
   chk_wait_enter:
   assert property (take && isWait |=> waitBusy && !stepDone) else $error("no wait");
   chk_no_spont:
   assert property (!$past(take) |-> seqIrq == 4'h0 && lineOut == '0)
      else $error("pulse without step");
   chk_wait_cause:
   assert property (stepDone && $past(waitBusy) |-> hist != 6'h00)
      else $error("wait ended without edge");
   cover property (take && isWait);
   cover property (stepDone && $past(waitBusy));
   cover property (lineOut.pwmSync != 2'h0);
endmodule
bind tsq_io_select tsq_io_select_sva u_sva (.core_clk(core_clk), .rst_b(rst_b),
   .stepValid(stepValid), .step(step), .stepDone(stepDone), .waitBusy(waitBusy),
   .eventSrc(eventSrc), .seqIrq(seqIrq), .lineOut(lineOut));

// file: dv/tb_tsq_io_select.sv
// Self-checking bench for the step decoder
module tb_tsq_io_select
   import tsq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic stepValid = 1'b0;
   tsq_step_t step = '0;
   logic [15:0] level = 16'h0000;
   logic stepDone;
   logic waitBusy;
   tsq_src_t eventSrc;
   logic [3:0] seqIrq;
   tsq_lines_t lineOut;
   int nErrors = 0;
   int compares = 0;
   int cyc = 0;
   logic [31:0] rng = 32'h6B44_4422;
   initial forever #4 core_clk = ~core_clk;
   tsq_peer_model u_peer (.core_clk(core_clk), .level(level), .eventSrc(eventSrc));
   tsq_io_select DUT (.core_clk(core_clk), .rst_b(rst_b), .stepValid(stepValid),
      .step(step), .stepDone(stepDone), .waitBusy(waitBusy), .eventSrc(eventSrc),
      .seqIrq(seqIrq), .lineOut(lineOut));
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   function automatic logic [20:0] expLine(input tsq_step_t s);
      logic [31:0] w;
      w = s.opcode[3:1] == 3'h4 ? (32'h1 << {s.opcode[0], s.option}) & 32'hFC03_1FFF : 32'h0;
      return {w[31:26], w[17:16], w[12:0]};
   endfunction
   function automatic logic [3:0] expIrq(input tsq_step_t s);
      return (s.opcode == 4'h7 && s.option < 4'h4) ? 4'h1 << s.option[1:0] : 4'h0;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (nErrors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Back to back: stepValid stays high across calls
   task automatic runStep(input tsq_step_t s);
      stepValid = 1'b1;
      step = s;
      @(negedge core_clk);
      check(lineOut, expLine(s));
      check(seqIrq, expIrq(s));
      check(stepDone, 1'b1);
   endtask
   task automatic waitCase(input logic [3:0] o, input logic rise);
      int k;
      stepValid = 1'b0;
      level = {16{~rise}};
      repeat (6) @(negedge core_clk);
      stepValid = 1'b1;
      step = {rise ? OPC_WAIT_RISE : OPC_WAIT_FALL, o};
      @(negedge core_clk);
      stepValid = 1'b0;
      level[o + 4'h1] = rise;
      repeat (6) @(negedge core_clk);
      check(waitBusy, 1'b1);
      level[o] = rise;
      k = 0;
      while (stepDone !== 1'b1 && k < 10) begin
         @(negedge core_clk);
         k++;
      end
      check(stepDone, 1'b1);
      check(waitBusy, 1'b0);
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         nErrors++;
         tally_and_finish();
      end
   end
   initial begin
      tsq_step_t s;
      repeat (20) @(negedge core_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 256; i++) begin
         if (i[7:5] != 3'h2) runStep(tsq_step_t'(i[7:0]));
      end
      for (int i = 0; i < 300; i++) begin
         rng = xorshift(rng);
         level = rng[31:16];
         s = rng[7:0];
         if (s.opcode[3:1] == 3'h2) s.opcode = 4'h7;
         runStep(s);
      end
      for (int o = 0; o < 16; o++) begin
         waitCase(o[3:0], 1'b1);
         waitCase(o[3:0], 1'b0);
      end
      // Reset in mid-wait abandons the wait; a step may follow at once
      level = 16'h0000;
      repeat (6) @(negedge core_clk);
      stepValid = 1'b1;
      step = {OPC_WAIT_RISE, 4'h3};
      @(negedge core_clk);
      stepValid = 1'b0;
      check(waitBusy, 1'b1);
      @(negedge core_clk);
      rst_b = 1'b0;
      repeat (2) @(negedge core_clk);
      check(waitBusy, 1'b0);
      check({stepDone, seqIrq, lineOut}, 32'h0);
      rst_b = 1'b1;
      runStep({OPC_IRQ, 4'h2});
      tally_and_finish();
   end
endmodule
